// File: core/pcc_pkg.sv
// Constants and types for the configuration command handler
package pcc_pkg;
  localparam int CLK_NS      = 40;
  localparam int HALF_MS_NS  = 500000;
  localparam int HALF_MS_CYC = (HALF_MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_W    = 4;
  // Command codes
  localparam logic [7:0] C_RUN   = 8'h01;
  localparam logic [7:0] C_START = 8'h02;
  localparam logic [7:0] C_STORE = 8'h11;
  localparam logic [7:0] C_VMODE = 8'h20;
  localparam logic [7:0] C_VOUT  = 8'h21;
  localparam logic [7:0] C_MHI   = 8'h25;
  localparam logic [7:0] C_MLO   = 8'h26;
  localparam logic [7:0] C_VON   = 8'h35;
  localparam logic [7:0] C_VOFF  = 8'h36;
  localparam logic [7:0] C_TDLY  = 8'h60;
  localparam logic [7:0] C_TRISE = 8'h61;
  // Number formats and ranges
  localparam logic [7:0]  VMODE_VAL = 8'h14;
  localparam logic [4:0]  EXP_VIN   = 5'h1D;
  localparam logic [4:0]  EXP_TON   = 5'h1F;
  localparam logic [10:0] VIN_MIN   = 11'h100;
  localparam logic [10:0] VIN_MAX   = 11'h170;
  localparam logic [10:0] TON_MIN   = 11'h050;
  localparam logic [10:0] TON_MAX   = 11'h3E8;
  localparam logic [15:0] VOUT_MIN  = 16'h5000;
  localparam logic [15:0] VOUT_MAX  = 16'hD333;
  localparam logic [7:0]  CRC_POLY  = 8'h07;
  // Field positions
  localparam int RUN_ON_BIT  = 7;
  localparam int CFG_CMD_BIT = 3;
  localparam int CFG_CPR_BIT = 2;
  localparam int CFG_POL_BIT = 1;
  localparam logic [7:0] CFG_WR_MASK = 8'h08;
  localparam logic [1:0] MARG_OFF    = 2'h0;
  localparam logic [3:0] MARG_LOW    = 4'h6;
  localparam logic [3:0] MARG_HIGH   = 4'hA;
  // Digit thresholds on the pin resistance code, in kilohms
  localparam logic [7:0] ADDR_TH [0:6] = '{8'h0C, 8'h13, 8'h1E, 8'h2D, 8'h45, 8'h6B, 8'hA5};

  typedef struct packed {
    logic [7:0]  run;
    logic [7:0]  start;
    logic [15:0] vout;
    logic [15:0] mhi;
    logic [15:0] mlo;
    logic [15:0] von;
    logic [15:0] voff;
    logic [15:0] tdly;
    logic [15:0] trise;
  } pcc_cfg_t;

  localparam pcc_cfg_t CFG_RST = '{8'h80, 8'h1F, 16'hC000, 16'hC800, 16'hB800,
                                   16'hE910, 16'hE900, 16'hF850, 16'hF850};

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_ACK   = 3'b011,
    ST_TX    = 3'b010,
    ST_TXACK = 3'b110
  } pcc_st_t;
endpackage : pcc_pkg

// File: core/pcc_core.sv
// Configuration command handler: bus slave, settings and on/off control
// What this block does
// - Bus address from two resistor pins, 64 addresses, answer only that one
// - Address is two octal digits; high pin upper, low pin lower
// - Resistor decodes ascending: 10 kilohm digit 0 to 200 kilohm digit 7
// - Transfers work at both 100 kHz and 400 kHz bus clocks
// - Output voltage words: unsigned 16-bit mantissa, exponent -12
// - Other quantities: 11-bit signed mantissa, 5-bit signed exponent on top
// - Run control bit 7: 0 disables, 1 enables output when obeyed
// - Startup config uses five low bits; bit 3 writable; all reset 1
// - Command-response bit 0 ignores the on bit; 1 obeys it
// - Stay off until both pin and run command enable, per bits 3:1
// - Never start unless the external on/off pin is asserted
// - Input thresholds accept 32 V to 46 V in 0.125 V steps
// - Input threshold exponent -3 in top five bits, mantissa MSB zero
// - Turn-on delay 40 ms to 500 ms in 0.5 ms steps
// - Rise time 40 ms to 500 ms in 0.5 ms steps
// - Delay and rise exponent -1, mantissa MSB zero
// - Set point 5.00 V to 13.20 V; exponent -12 readable from mode
// - Separate margin high and low settings, exponent -12
// - Run control bits 5:2: 00XX off, 0110 low, 1010 high
// - Settings go to storage only on the store-all command
// - Check packet error byte if sent, never require it, append to reads
// - Never stretches the clock, so never beyond 35 ms
// - No direct format; exponents fixed and not host-changeable
`timescale 1ns/1ps
module pcc_core #(
  parameter int HALF_MS_CYC = pcc_pkg::HALF_MS_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_link_clk,
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_sda_o,
  output logic                  o_sda_oe,
  input  wire logic [7:0]       i_high_address_digit_pin,
  input  wire logic [7:0]       i_low_address_digit_pin,
  input  wire logic             i_on_off_pin,
  output logic [5:0]            o_bus_addr,
  output logic                  o_output_on,
  output logic [15:0]           o_vout_target,
  output pcc_pkg::pcc_cfg_t     o_cfg,
  output logic                  o_nvm_store
);

  // Link domain
  logic             scl_m, scl_s, scl_q;
  logic             sda_m, sda_s, sda_q;
  logic [7:0]       ahi_m, ahi_s, alo_m, alo_s;
  logic [pcc_pkg::SETTLE_W-1:0] settle_r;
  logic             addr_ok_r;
  logic [5:0]       addr_r;
  pcc_pkg::pcc_st_t st_r;
  logic [3:0]       bit_r;
  logic [7:0]       sh_r;
  logic [7:0]       tx_sh_r;
  logic [2:0]       tx_idx_r;
  logic [2:0]       cnt_r;
  logic [7:0]       cmd_r;
  logic [7:0]       d0_r;
  logic [7:0]       d1_r;
  logic [7:0]       crc_r;
  logic             adr_r;
  logic             rd_r;
  logic             ours_r;
  logic             frame_r;
  logic             nak_r;
  logic             sda_oe_r;
  pcc_pkg::pcc_cfg_t cfg_r;
  pcc_pkg::pcc_cfg_t snap_r;
  logic             snap_store_r;
  logic             dirty_r;
  logic             store_r;
  logic             req_r;
  logic             ack_m, ack_s;
  logic             scl_rise, scl_fall, start_ev, stop_ev;
  logic [2:0]       len;
  logic [2:0]       nbytes;
  logic             wr_ok, len_ok, wr_commit, launch;
  logic [15:0]      word;
  logic [15:0]      rd_word;
  logic [7:0]       txb;
  // Core domain
  logic             req_m, req_s, ack_r;
  logic             pin_m, pin_s;
  logic             en_req;
  logic [15:0]      tick_r;
  logic [10:0]      dly_r;
  pcc_pkg::pcc_cfg_t core_cfg_r;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ pcc_pkg::CRC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction : crc8

  function automatic logic [2:0] digit(input logic [7:0] code);
    logic [2:0] d;
    d = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (code >= pcc_pkg::ADDR_TH[i]) begin
        d = d + 3'h1;
      end
    end
    return d;
  endfunction : digit

  function automatic logic lin_ok(input logic [15:0] w, input logic [4:0] e,
                                  input logic [10:0] lo, input logic [10:0] hi);
    return (w[15:11] == e) && (w[10:0] >= lo) && (w[10:0] <= hi);
  endfunction : lin_ok

  function automatic logic [2:0] cmd_len(input logic [7:0] c);
    logic [2:0] r;
    r = 3'b000;
    case (c)
      pcc_pkg::C_STORE: r = 3'b100;
      pcc_pkg::C_RUN, pcc_pkg::C_START, pcc_pkg::C_VMODE: r = 3'b101;
      pcc_pkg::C_VOUT, pcc_pkg::C_MHI, pcc_pkg::C_MLO, pcc_pkg::C_VON,
      pcc_pkg::C_VOFF, pcc_pkg::C_TDLY, pcc_pkg::C_TRISE: r = 3'b110;
      default: r = 3'b000;
    endcase
    return r;
  endfunction : cmd_len

  // Oversampled bus lines, two stages then a history stage
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

  // Address pins sampled once after reset settles
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      ahi_m     <= 8'h00;
      ahi_s     <= 8'h00;
      alo_m     <= 8'h00;
      alo_s     <= 8'h00;
      settle_r  <= '0;
      addr_ok_r <= 1'b0;
      addr_r    <= 6'h00;
    end else begin
      ahi_m <= i_high_address_digit_pin;
      ahi_s <= ahi_m;
      alo_m <= i_low_address_digit_pin;
      alo_s <= alo_m;
      if (!addr_ok_r) begin
        settle_r <= settle_r + 1'b1;
        if (&settle_r) begin
          addr_ok_r <= 1'b1;
          addr_r    <= {digit(ahi_s), digit(alo_s)};
        end
      end
    end
  end

  // Write checks
  assign word   = {d1_r, d0_r};
  assign len    = cmd_len(cmd_r);
  assign nbytes = cnt_r - 3'h1;
  assign len_ok = (nbytes == {1'b0, len[1:0]}) ||
                  ((nbytes == {1'b0, len[1:0]} + 3'h1) && (crc_r == 8'h00));

  always_comb begin
    wr_ok = 1'b0;
    case (cmd_r)
      pcc_pkg::C_RUN: begin
        wr_ok = (d0_r[5:4] == pcc_pkg::MARG_OFF) || (d0_r[5:2] == pcc_pkg::MARG_LOW) ||
                (d0_r[5:2] == pcc_pkg::MARG_HIGH);
      end
      pcc_pkg::C_START, pcc_pkg::C_STORE: wr_ok = 1'b1;
      pcc_pkg::C_VOUT, pcc_pkg::C_MHI, pcc_pkg::C_MLO: begin
        wr_ok = (word >= pcc_pkg::VOUT_MIN) && (word <= pcc_pkg::VOUT_MAX);
      end
      pcc_pkg::C_VON, pcc_pkg::C_VOFF: begin
        wr_ok = lin_ok(word, pcc_pkg::EXP_VIN, pcc_pkg::VIN_MIN, pcc_pkg::VIN_MAX);
      end
      pcc_pkg::C_TDLY, pcc_pkg::C_TRISE: begin
        wr_ok = lin_ok(word, pcc_pkg::EXP_TON, pcc_pkg::TON_MIN, pcc_pkg::TON_MAX);
      end
      default: wr_ok = 1'b0;
    endcase
  end

  assign wr_commit = stop_ev & ours_r & ~rd_r & len[2] & len_ok & wr_ok;

  // Read data
  always_comb begin
    rd_word = 16'h0000;
    case (cmd_r)
      pcc_pkg::C_RUN:   rd_word = {8'h00, cfg_r.run};
      pcc_pkg::C_START: rd_word = {8'h00, cfg_r.start};
      pcc_pkg::C_VMODE: rd_word = {8'h00, pcc_pkg::VMODE_VAL};
      pcc_pkg::C_VOUT:  rd_word = cfg_r.vout;
      pcc_pkg::C_MHI:   rd_word = cfg_r.mhi;
      pcc_pkg::C_MLO:   rd_word = cfg_r.mlo;
      pcc_pkg::C_VON:   rd_word = cfg_r.von;
      pcc_pkg::C_VOFF:  rd_word = cfg_r.voff;
      pcc_pkg::C_TDLY:  rd_word = cfg_r.tdly;
      pcc_pkg::C_TRISE: rd_word = cfg_r.trise;
      default:          rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    txb = 8'hFF;
    if (tx_idx_r < {1'b0, len[1:0]}) begin
      txb = tx_idx_r[0] ? rd_word[15:8] : rd_word[7:0];
    end else if (tx_idx_r == {1'b0, len[1:0]}) begin
      txb = crc_r;
    end
  end

  // Bus slave framing; the clock line is never held low
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r     <= pcc_pkg::ST_IDLE;
      bit_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_sh_r  <= 8'h00;
      tx_idx_r <= 3'h0;
      cnt_r    <= 3'h0;
      cmd_r    <= 8'h00;
      d0_r     <= 8'h00;
      d1_r     <= 8'h00;
      crc_r    <= 8'h00;
      adr_r    <= 1'b0;
      rd_r     <= 1'b0;
      ours_r   <= 1'b0;
      frame_r  <= 1'b0;
      nak_r    <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_ev) begin
      st_r     <= pcc_pkg::ST_RX;
      bit_r    <= 4'h0;
      adr_r    <= 1'b1;
      sda_oe_r <= 1'b0;
      frame_r  <= 1'b1;
      if (!frame_r) begin
        crc_r  <= 8'h00;
        cnt_r  <= 3'h0;
        ours_r <= 1'b0;
      end
    end else if (stop_ev) begin
      st_r     <= pcc_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
      frame_r  <= 1'b0;
      ours_r   <= 1'b0;
    end else begin
      unique case (st_r)
        pcc_pkg::ST_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        pcc_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_s};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            crc_r    <= crc8(crc_r, sh_r);
            st_r     <= pcc_pkg::ST_ACK;
            sda_oe_r <= 1'b1;
            if (adr_r) begin
              adr_r    <= 1'b0;
              rd_r     <= sh_r[0];
              tx_idx_r <= 3'h0;
              if (addr_ok_r && sh_r[7:1] == {1'b0, addr_r}) begin
                ours_r <= 1'b1;
              end else begin
                ours_r   <= 1'b0;
                st_r     <= pcc_pkg::ST_IDLE;
                sda_oe_r <= 1'b0;
              end
            end else begin
              if (cnt_r != 3'h4) begin
                cnt_r <= cnt_r + 3'h1;
              end
              if (cnt_r == 3'h0) begin
                cmd_r <= sh_r;
              end
              if (cnt_r == 3'h1) begin
                d0_r <= sh_r;
              end
              if (cnt_r == 3'h2) begin
                d1_r <= sh_r;
              end
              if ((cnt_r == 3'h0 && cmd_len(sh_r) < 3'b100) || cnt_r == 3'h4) begin
                ours_r   <= 1'b0;
                st_r     <= pcc_pkg::ST_IDLE;
                sda_oe_r <= 1'b0;
              end
            end
          end
        end
        pcc_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_r <= 4'h0;
            if (rd_r) begin
              st_r     <= pcc_pkg::ST_TX;
              tx_sh_r  <= txb;
              sda_oe_r <= ~txb[7];
              crc_r    <= crc8(crc_r, txb);
              tx_idx_r <= (tx_idx_r == 3'h7) ? tx_idx_r : tx_idx_r + 3'h1;
            end else begin
              st_r     <= pcc_pkg::ST_RX;
              sda_oe_r <= 1'b0;
            end
          end
        end
        pcc_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_r == 4'h7) begin
              st_r     <= pcc_pkg::ST_TXACK;
              sda_oe_r <= 1'b0;
            end else begin
              bit_r    <= bit_r + 4'h1;
              tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
              sda_oe_r <= ~tx_sh_r[6];
            end
          end
        end
        pcc_pkg::ST_TXACK: begin
          if (scl_rise) begin
            nak_r <= sda_s;
          end else if (scl_fall) begin
            if (nak_r) begin
              st_r <= pcc_pkg::ST_IDLE;
            end else begin
              st_r     <= pcc_pkg::ST_TX;
              bit_r    <= 4'h0;
              tx_sh_r  <= txb;
              sda_oe_r <= ~txb[7];
              crc_r    <= crc8(crc_r, txb);
              tx_idx_r <= (tx_idx_r == 3'h7) ? tx_idx_r : tx_idx_r + 3'h1;
            end
          end
        end
        default: begin
          st_r     <= pcc_pkg::ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = sda_oe_r;

  // Settings updated only by a checked write
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= pcc_pkg::CFG_RST;
    end else if (wr_commit) begin
      case (cmd_r)
        pcc_pkg::C_RUN:   cfg_r.run   <= d0_r;
        pcc_pkg::C_START: begin
          cfg_r.start <= (cfg_r.start & ~pcc_pkg::CFG_WR_MASK) |
                         (d0_r & pcc_pkg::CFG_WR_MASK);
        end
        pcc_pkg::C_VOUT:  cfg_r.vout  <= word;
        pcc_pkg::C_MHI:   cfg_r.mhi   <= word;
        pcc_pkg::C_MLO:   cfg_r.mlo   <= word;
        pcc_pkg::C_VON:   cfg_r.von   <= word;
        pcc_pkg::C_VOFF:  cfg_r.voff  <= word;
        pcc_pkg::C_TDLY:  cfg_r.tdly  <= word;
        pcc_pkg::C_TRISE: cfg_r.trise <= word;
        default:          cfg_r       <= cfg_r;
      endcase
    end
  end

  // Settings snapshot sent to core clock by toggle handshake
  assign launch = dirty_r & (req_r == ack_s);

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_m        <= 1'b0;
      ack_s        <= 1'b0;
      req_r        <= 1'b0;
      dirty_r      <= 1'b0;
      store_r      <= 1'b0;
      snap_r       <= pcc_pkg::CFG_RST;
      snap_store_r <= 1'b0;
    end else begin
      ack_m   <= ack_r;
      ack_s   <= ack_m;
      dirty_r <= wr_commit | (dirty_r & ~launch);
      store_r <= (wr_commit & (cmd_r == pcc_pkg::C_STORE)) | (store_r & ~launch);
      if (launch) begin
        snap_r       <= cfg_r;
        snap_store_r <= store_r;
        req_r        <= ~req_r;
      end
    end
  end

  // Core side capture
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req_m       <= 1'b0;
      req_s       <= 1'b0;
      ack_r       <= 1'b0;
      core_cfg_r  <= pcc_pkg::CFG_RST;
      o_nvm_store <= 1'b0;
    end else begin
      req_m       <= req_r;
      req_s       <= req_m;
      o_nvm_store <= 1'b0;
      if (req_s != ack_r) begin
        ack_r       <= req_s;
        core_cfg_r  <= snap_r;
        o_nvm_store <= snap_store_r;
      end
    end
  end

  assign o_cfg = core_cfg_r;

  // On/off pin sync
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_m <= 1'b0;
      pin_s <= 1'b0;
    end else begin
      pin_m <= i_on_off_pin;
      pin_s <= pin_m;
    end
  end

  always_comb begin
    en_req = (core_cfg_r.start[pcc_pkg::CFG_POL_BIT] ? pin_s : ~pin_s) |
             ~core_cfg_r.start[pcc_pkg::CFG_CPR_BIT];
    en_req = en_req & (~core_cfg_r.start[pcc_pkg::CFG_CMD_BIT] |
                       core_cfg_r.run[pcc_pkg::RUN_ON_BIT]);
  end

  // Turn-on delay in half-millisecond ticks
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_r      <= 16'h0000;
      dly_r       <= 11'h000;
      o_output_on <= 1'b0;
    end else if (!en_req) begin
      tick_r      <= 16'h0000;
      dly_r       <= 11'h000;
      o_output_on <= 1'b0;
    end else if (!o_output_on) begin
      if (dly_r >= core_cfg_r.tdly[10:0]) begin
        o_output_on <= 1'b1;
      end else if (tick_r == 16'(HALF_MS_CYC - 1)) begin
        tick_r <= 16'h0000;
        dly_r  <= dly_r + 11'h001;
      end else begin
        tick_r <= tick_r + 16'h0001;
      end
    end
  end

  // Output target by margin selection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_vout_target <= pcc_pkg::CFG_RST.vout;
    end else if (core_cfg_r.run[5:2] == pcc_pkg::MARG_LOW) begin
      o_vout_target <= core_cfg_r.mlo;
    end else if (core_cfg_r.run[5:2] == pcc_pkg::MARG_HIGH) begin
      o_vout_target <= core_cfg_r.mhi;
    end else begin
      o_vout_target <= core_cfg_r.vout;
    end
  end

  assign o_bus_addr = addr_r;

endmodule : pcc_core

// File: sim/pcc_core_sva.sv
// Port-level assertions for the configuration command handler
`timescale 1ns/1ps
module pcc_core_sva #(
  parameter int HALF_MS_CYC = 4
) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_on_off_pin,
  input wire logic              o_sda_oe,
  input wire logic [5:0]        o_bus_addr,
  input wire logic              o_output_on,
  input wire logic [15:0]       o_vout_target,
  input wire pcc_pkg::pcc_cfg_t o_cfg,
  input wire logic              o_nvm_store
);
  int unsigned wait_cnt;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst || o_output_on || !i_on_off_pin) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_reset_cfg: assert property ($past(i_rst) |-> o_cfg == pcc_pkg::CFG_RST)
    else $error("settings not at reset values");
  a_vin_format: assert property (o_cfg.von[15:10] == {pcc_pkg::EXP_VIN, 1'b0}
    && o_cfg.voff[15:10] == {pcc_pkg::EXP_VIN, 1'b0}) else $error("threshold format");
  a_ton_range: assert property (o_cfg.tdly[10:0] >= pcc_pkg::TON_MIN
    && o_cfg.tdly[10:0] <= pcc_pkg::TON_MAX) else $error("delay out of range");
  a_vout_range: assert property (o_cfg.vout >= pcc_pkg::VOUT_MIN
    && o_cfg.vout <= pcc_pkg::VOUT_MAX) else $error("set point out of range");
  a_start_bits: assert property ((o_cfg.start | 8'h08) == 8'h1F)
    else $error("read-only startup bits changed");
  a_pin_gates: assert property (!i_on_off_pin [*6] |-> !o_output_on)
    else $error("output on without pin");
  a_cmd_off: assert property ((o_cfg.start[3] && !o_cfg.run[7]) [*4] |-> !o_output_on)
    else $error("output on against run bit");
  a_margin_sel: assert property (o_cfg == $past(o_cfg) && o_cfg == $past(o_cfg, 2)
    && o_cfg.run[5:2] == pcc_pkg::MARG_HIGH |-> o_vout_target == o_cfg.mhi)
    else $error("margin high not selected");
  a_on_delay: assert property ($rose(o_output_on)
    |-> wait_cnt >= HALF_MS_CYC * o_cfg.tdly[9:0]) else $error("turn-on delay too short");
  a_store_pulse: assert property (o_nvm_store |=> !o_nvm_store)
    else $error("store pulse too long");
  c_store: cover property (o_nvm_store);
  c_on: cover property ($rose(o_output_on));
  c_ack: cover property ($rose(o_sda_oe) && o_bus_addr != 6'h00);
endmodule : pcc_core_sva
bind pcc_core pcc_core_sva #(.HALF_MS_CYC(HALF_MS_CYC)) i_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_on_off_pin(i_on_off_pin), .o_sda_oe(o_sda_oe), .o_bus_addr(o_bus_addr),
  .o_output_on(o_output_on), .o_vout_target(o_vout_target), .o_cfg(o_cfg),
  .o_nvm_store(o_nvm_store));

// File: sim/pcc_host.sv
// Bus host model: clock and data driver with packet error byte
`timescale 1ns/1ps
module pcc_host (
  output logic      o_scl,
  output logic      o_sda_oe,
  input  wire logic i_sda
);
  int         hp = 1250;
  logic       ack;
  logic [7:0] crc;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    end
    return r;
  endfunction : crc8
  task automatic start();
    #(hp / 2) o_sda_oe = 1'b0;
    #(hp / 2) o_scl = 1'b1;
    #hp o_sda_oe = 1'b1;
    #hp o_scl = 1'b0;
  endtask : start
  task automatic stop();
    #(hp / 2) o_sda_oe = 1'b1;
    #(hp / 2) o_scl = 1'b1;
    #hp o_sda_oe = 1'b0;
    #(4 * hp);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    #(hp / 2) o_sda_oe = !b;
    #(hp / 2) o_scl = 1'b1;
    #(hp / 2) r = i_sda;
    #(hp / 2) o_scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic n9, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    crc = crc8(crc, q);
    bit_io(n9, s);
    ack = !s;
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    input int n, input int pec);
    logic [7:0] q;
    crc = 8'h00;
    start();
    xfer({a, 1'b0}, 1'b1, q);
    if (ack) begin
      xfer(c, 1'b1, q);
      for (int i = 0; i < n; i++) begin
        xfer(d[8 * i +: 8], 1'b1, q);
      end
      if (pec > 0) begin
        xfer(crc ^ 8'(pec - 1), 1'b1, q);
      end
    end
    stop();
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n,
                    output logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic [7:0] e;
    d = 16'h0000;
    crc = 8'h00;
    start();
    xfer({a, 1'b0}, 1'b1, q);
    xfer(c, 1'b1, q);
    start();
    xfer({a, 1'b1}, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, 1'b0, q);
      d[8 * i +: 8] = q;
    end
    e = crc;
    xfer(8'hFF, 1'b1, q);
    ok = (q == e);
    stop();
  endtask : rd
endmodule : pcc_host

// File: sim/testbench.sv
// Self-checking bench for the configuration command handler
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] ADR = 7'h1D;
  typedef struct packed {
    logic [7:0]  c;
    logic [15:0] v;
    logic [15:0] e;
    logic [1:0]  p;
  } pcc_ent_t;
  logic              clk = 1'b0;
  logic              link_clk = 1'b0;
  logic              rst = 1'b1;
  logic              on_pin = 1'b0;
  logic [7:0]        hi_pin = 8'h25;
  logic [7:0]        lo_pin = 8'h55;
  logic              scl, host_oe, dut_oe, dut_o, out_on, store, ok;
  wire               sda;
  logic [5:0]        bus_addr;
  logic [15:0]       target, d;
  pcc_pkg::pcc_cfg_t cfg;
  int                error_cnt = 0, n_checks = 0, cyc = 0, stores = 0, cnt;
  logic [7:0]        tab [8] = '{8'h0A, 8'h0F, 8'h18, 8'h25, 8'h37, 8'h55, 8'h82, 8'hC8};
  pcc_ent_t          ents [12] = '{
    '{pcc_pkg::C_VOUT, 16'h6000, 16'h6000, 2'h0}, '{pcc_pkg::C_VOUT, 16'hD334, 16'h6000, 2'h0},
    '{pcc_pkg::C_VOUT, 16'h7000, 16'h6000, 2'h2}, '{pcc_pkg::C_VOUT, 16'h7000, 16'h7000, 2'h1},
    '{pcc_pkg::C_VON, 16'hE970, 16'hE970, 2'h0}, '{pcc_pkg::C_VON, 16'hF150, 16'hE970, 2'h0},
    '{pcc_pkg::C_VOFF, 16'hE950, 16'hE950, 2'h0}, '{pcc_pkg::C_TDLY, 16'hFBE9, 16'hF850, 2'h0},
    '{pcc_pkg::C_TRISE, 16'hFBE8, 16'hFBE8, 2'h0}, '{pcc_pkg::C_TRISE, 16'hF84F, 16'hFBE8, 2'h0},
    '{pcc_pkg::C_MHI, 16'hD333, 16'hD333, 2'h0}, '{pcc_pkg::C_MLO, 16'h4FFF, 16'hB800, 2'h0}};
  assign sda = !(host_oe || (dut_oe && !dut_o));
  pcc_host i_host (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));
  pcc_core #(.HALF_MS_CYC(4)) i_dut (.i_clk(clk), .i_rst(rst), .i_link_clk(link_clk),
    .i_scl(scl), .i_sda(sda), .o_sda_o(dut_o), .o_sda_oe(dut_oe),
    .i_high_address_digit_pin(hi_pin), .i_low_address_digit_pin(lo_pin),
    .i_on_off_pin(on_pin), .o_bus_addr(bus_addr), .o_output_on(out_on),
    .o_vout_target(target), .o_cfg(cfg), .o_nvm_store(store));
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tdone(input string s);
    $display("TB: test %s done", s);
  endtask : tdone
  task automatic results();
    $display("TB: %0d checks, %0d mismatches", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  task automatic rst_run(input logic [7:0] h, input logic [7:0] l);
    @(negedge clk);
    rst = 1'b1;
    hi_pin = h;
    lo_pin = l;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (30) @(posedge link_clk);
  endtask : rst_run
  function automatic logic [15:0] fld(input logic [7:0] c);
    case (c)
      pcc_pkg::C_VOUT: return cfg.vout;
      pcc_pkg::C_VON: return cfg.von;
      pcc_pkg::C_VOFF: return cfg.voff;
      pcc_pkg::C_TDLY: return cfg.tdly;
      pcc_pkg::C_TRISE: return cfg.trise;
      pcc_pkg::C_MHI: return cfg.mhi;
      default: return cfg.mlo;
    endcase
  endfunction : fld
  task automatic run_tgt(input logic [7:0] v, input logic [7:0] er, input logic [15:0] et);
    i_host.wr(ADR, pcc_pkg::C_RUN, {8'h00, v}, 1, 0);
    chk("run", {8'h00, er}, {8'h00, cfg.run});
    chk("target", et, target);
  endtask : run_tgt
  task automatic on_chk(input string nm, input logic e);
    chk(nm, {15'h0, e}, {15'h0, out_on});
  endtask : on_chk
  always @(posedge clk) begin
    cyc++;
    if (store === 1'b1) begin
      stores++;
    end
    if (cyc == 90000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      rst_run(tab[i], tab[7 - i]);
      chk("bus_addr", 16'(7 * i + 7), {10'h0, bus_addr});
    end
    rst_run(8'h25, 8'h55);
    tdone("address");
    i_host.rd(ADR, pcc_pkg::C_START, 1, d, ok);
    chk("start_cfg", 16'h001F, d);
    i_host.wr(ADR, pcc_pkg::C_START, 16'h0000, 1, 0);
    chk("start_ro", 16'h0017, {8'h00, cfg.start});
    i_host.wr(ADR, pcc_pkg::C_VMODE, 16'h0000, 1, 0);
    i_host.rd(ADR, pcc_pkg::C_VMODE, 1, d, ok);
    chk("vout_mode", 16'h0014, d);
    chk("read_pec", 16'h0001, {15'h0, ok});
    i_host.wr(ADR - 7'h01, pcc_pkg::C_RUN, 16'h0000, 1, 0);
    chk("foreign_ack", 16'h0000, {15'h0, i_host.ack});
    tdone("registers");
    foreach (ents[i]) begin
      i_host.hp = (i == 0) ? 5000 : 1250;
      i_host.wr(ADR, ents[i].c, ents[i].v, 2, int'(ents[i].p));
      chk("setting", ents[i].e, fld(ents[i].c));
    end
    i_host.wr(ADR, pcc_pkg::C_MLO, 16'h5000, 2, 0);
    tdone("settings");
    run_tgt(8'hA8, 8'hA8, 16'hD333);
    run_tgt(8'h98, 8'h98, 16'h5000);
    run_tgt(8'h9C, 8'h98, 16'h5000);
    run_tgt(8'h80, 8'h80, 16'h7000);
    tdone("margin");
    i_host.wr(ADR, pcc_pkg::C_START, 16'h0008, 1, 0);
    on_chk("off_no_pin", 1'b0);
    @(negedge clk);
    on_pin = 1'b1;
    cnt = 0;
    while (out_on !== 1'b1 && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
    chk("on_delay", 16'h0001, 16'(cnt >= 321 && cnt <= 330));
    i_host.wr(ADR, pcc_pkg::C_RUN, 16'h0000, 1, 0);
    on_chk("off_cmd", 1'b0);
    i_host.wr(ADR, pcc_pkg::C_START, 16'h0000, 1, 0);
    repeat (400) @(negedge clk);
    on_chk("cmd_ignored", 1'b1);
    on_pin = 1'b0;
    repeat (6) @(negedge clk);
    on_chk("pin_off", 1'b0);
    tdone("on_off");
    chk("no_auto_store", 16'h0000, 16'(stores));
    i_host.wr(ADR, pcc_pkg::C_STORE, 16'h0000, 0, 0);
    chk("store", 16'h0001, 16'(stores));
    tdone("store");
    results();
  end
endmodule : testbench
